// ---- include/bprc_cfg.svh ----
// register map, field positions, reset values and timing counts
`ifndef BPRC_CFG_SVH
`define BPRC_CFG_SVH

// protection setting register
`define BPRC_ADDR_W          6
`define BPRC_ADDR_PROT       6'h1b
`define BPRC_PROT_RESET      8'h44
`define BPRC_CB_IV_LSB       6
`define BPRC_CB_OC_LSB       4
`define BPRC_IB_IV_LSB       2
`define BPRC_IB_OC_LSB       0

// fault flag bit positions
`define BPRC_NFLAG           7
`define BPRC_IB_OV           0
`define BPRC_IB_OC           1
`define BPRC_IB_LV           2
`define BPRC_CB_OV           3
`define BPRC_CB_OC           4
`define BPRC_CB_LV           5
`define BPRC_ALR_OV          6

// clock and times in ns
`define BPRC_CLK_NS          100
`define BPRC_T_FIX_MASK_NS   92000
`define BPRC_T_OC_SHORT_NS   122000
`define BPRC_T_OC_MID_NS     610000
`define BPRC_T_OC_LONG_NS    1098000
`define BPRC_T_IV_0_NS       15600000
`define BPRC_T_IV_1_NS       31200000
`define BPRC_T_IV_2_NS       124900000
`define BPRC_T_IV_3_NS       249900000
`define BPRC_T_RST_DLY_NS    12000000

// cycle counts, least times rounded up
`define BPRC_CYC(t)          (((t) + `BPRC_CLK_NS - 1) / `BPRC_CLK_NS)
`define BPRC_FIX_MASK_CYC    `BPRC_CYC(`BPRC_T_FIX_MASK_NS)
`define BPRC_OC_SHORT_CYC    `BPRC_CYC(`BPRC_T_OC_SHORT_NS)
`define BPRC_OC_MID_CYC      `BPRC_CYC(`BPRC_T_OC_MID_NS)
`define BPRC_OC_LONG_CYC     `BPRC_CYC(`BPRC_T_OC_LONG_NS)
`define BPRC_IV_0_CYC        `BPRC_CYC(`BPRC_T_IV_0_NS)
`define BPRC_IV_1_CYC        `BPRC_CYC(`BPRC_T_IV_1_NS)
`define BPRC_IV_2_CYC        `BPRC_CYC(`BPRC_T_IV_2_NS)
`define BPRC_IV_3_CYC        `BPRC_CYC(`BPRC_T_IV_3_NS)
`define BPRC_RST_DLY_CYC     `BPRC_CYC(`BPRC_T_RST_DLY_NS)

`endif

// ---- include/bprc_pkg.sv ----
// types shared by the protection and retry control block
package bprc_pkg;

    // gray order along run -> arm -> off -> try -> run
    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_arm = 2'b01,
        st_off = 2'b11,
        st_try = 2'b10
    } bprc_state_e;

endpackage

// ---- src/bprc_sync3.sv ----
// three-stage synchroniser, output follows once stages two and three agree
module bprc_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } bprc_sync_s;

    bprc_sync_s sync_q;
    bprc_sync_s sync_d;

    always_comb begin
        sync_d     = sync_q;
        sync_d.s1  = din;
        sync_d.s2  = sync_q.s1;
        sync_d.s3  = sync_q.s2;
        // stage one stays out of the compare to keep metastability contained
        sync_d.val = (~(sync_q.s2 ^ sync_q.s3) & sync_q.s3)
                   | ((sync_q.s2 ^ sync_q.s3) & sync_q.val);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_q <= '0;
        end else if (clk_en) begin
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q.val;

endmodule

// ---- src/bprc_core.sv ----
// buck fault protection, retry control and core rail reset generation
//
// What this block does
// - any buck out-of-range detection sets its status flag and interrupt
// - intermediate buck over-voltage halts switching of both bucks at once
// - intermediate over-current or low voltage past mask enters retry mode
// - fixed 92us mask for low voltage and core fault; current mask set
// - intermediate buck in protect retries at its programmed interval
// - retry with fault cause gone returns intermediate buck to normal
// - core buck or analog regulator over-voltage forces intermediate protect
// - interrupt goes low before intermediate buck enters protect mode
// - core over-current or low voltage past mask enters retry mode
// - core buck in protect retries at its own programmed interval
// - core buck over-voltage halts switching of both bucks
// - interrupt goes low before core buck enters protect mode
// - optional core low-voltage reset, held while low, released 12ms later
// - setting register 1bh holds four two-bit interval and mask fields
// - interval codes select 15.6, 31.2 (default), 124.9, 249.9 ms
// - mask codes select 122 (default), 122, 610, 1098 us
// - setting register survives system reset, set back to 44h only by rst
`include "bprc_cfg.svh"

module bprc_core #(
    parameter int CNT_W        = 22,
    parameter int FIX_MASK_CYC = `BPRC_FIX_MASK_CYC,
    parameter int OC_SHORT_CYC = `BPRC_OC_SHORT_CYC,
    parameter int OC_MID_CYC   = `BPRC_OC_MID_CYC,
    parameter int OC_LONG_CYC  = `BPRC_OC_LONG_CYC,
    parameter int IV_0_CYC     = `BPRC_IV_0_CYC,
    parameter int IV_1_CYC     = `BPRC_IV_1_CYC,
    parameter int IV_2_CYC     = `BPRC_IV_2_CYC,
    parameter int IV_3_CYC     = `BPRC_IV_3_CYC,
    parameter int RST_DLY_CYC  = `BPRC_RST_DLY_CYC
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    input  wire logic                     ib_ov_det,
    input  wire logic                     ib_oc_det,
    input  wire logic                     ib_lv_det,
    input  wire logic                     cb_ov_det,
    input  wire logic                     cb_oc_det,
    input  wire logic                     cb_lv_det,
    input  wire logic                     alr_ov_det,
    input  wire logic                     core_lv_reset_en,
    input  wire logic [`BPRC_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic [`BPRC_NFLAG-1:0]   flag_clear,
    output logic      [7:0]               reg_rdata,
    output logic      [`BPRC_NFLAG-1:0]   fault_flags,
    output logic                          fault_interrupt_n,
    output logic                          intermediate_buck_switch_en,
    output logic                          core_buck_switch_en,
    output logic                          intermediate_buck_protect,
    output logic                          core_buck_protect,
    output logic                          system_reset_n
);

    localparam int NCH = 2;

    typedef logic [CNT_W-1:0] bprc_cnt_t;

    typedef struct packed {
        logic [7:0]                        prot;
        logic [7:0]                        rdata;
        logic [`BPRC_NFLAG-1:0]            flags;
        logic                              int_n;
        bprc_pkg::bprc_state_e [NCH-1:0]   st;
        logic [NCH-1:0][CNT_W-1:0]         oc_cnt;
        logic [NCH-1:0][CNT_W-1:0]         lv_cnt;
        logic [CNT_W-1:0]                  cbov_cnt;
        logic [NCH-1:0][CNT_W-1:0]         tmr;
        logic [NCH-1:0]                    sw_en;
        logic [NCH-1:0]                    prot_mode;
        logic                              rst_n;
        logic [CNT_W-1:0]                  rst_cnt;
    } bprc_core_s;

    bprc_core_s              core_q;
    bprc_core_s              core_d;

    logic [`BPRC_NFLAG-1:0]  det_raw;
    logic [`BPRC_NFLAG-1:0]  det;
    logic                    halt;
    logic                    cbov_exp;
    logic [NCH-1:0]          cond_oc;
    logic [NCH-1:0]          cond_lv;
    logic [NCH-1:0]          hard_raw;
    logic [NCH-1:0]          hard_trig;
    logic [NCH-1:0]          oc_exp;
    logic [NCH-1:0]          lv_exp;
    logic [NCH-1:0]          trig;
    logic [NCH-1:0]          cause;
    bprc_cnt_t [NCH-1:0]     oc_last;
    bprc_cnt_t [NCH-1:0]     iv_last;

    // last count of a window, never below zero
    function automatic bprc_cnt_t last_f(input int cyc);
        last_f = (cyc > 1) ? CNT_W'(cyc - 1) : '0;
    endfunction

    function automatic bprc_cnt_t oc_mask_f(input logic [1:0] sel);
        case (sel)
            2'b10:   oc_mask_f = last_f(OC_MID_CYC);
            2'b11:   oc_mask_f = last_f(OC_LONG_CYC);
            default: oc_mask_f = last_f(OC_SHORT_CYC);
        endcase
    endfunction

    function automatic bprc_cnt_t iv_f(input logic [1:0] sel);
        case (sel)
            2'b00:   iv_f = last_f(IV_0_CYC);
            2'b10:   iv_f = last_f(IV_2_CYC);
            2'b11:   iv_f = last_f(IV_3_CYC);
            default: iv_f = last_f(IV_1_CYC);
        endcase
    endfunction

    // detector outputs come from the analog side, so they are resynchronised
    assign det_raw[`BPRC_IB_OV]  = ib_ov_det;
    assign det_raw[`BPRC_IB_OC]  = ib_oc_det;
    assign det_raw[`BPRC_IB_LV]  = ib_lv_det;
    assign det_raw[`BPRC_CB_OV]  = cb_ov_det;
    assign det_raw[`BPRC_CB_OC]  = cb_oc_det;
    assign det_raw[`BPRC_CB_LV]  = cb_lv_det;
    assign det_raw[`BPRC_ALR_OV] = alr_ov_det;

    bprc_sync3 #(
        .WIDTH (`BPRC_NFLAG)
    ) u_det_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .din     (det_raw),
        .dout    (det)
    );

    // cause decode, channel 0 intermediate buck, channel 1 core buck
    always_comb begin
        halt = det[`BPRC_IB_OV] | det[`BPRC_CB_OV];
        cond_oc[0]  = det[`BPRC_IB_OC];
        cond_oc[1]  = det[`BPRC_CB_OC];
        cond_lv[0]  = det[`BPRC_IB_LV];
        cond_lv[1]  = det[`BPRC_CB_LV];
        hard_raw[0] = det[`BPRC_IB_OV] | det[`BPRC_ALR_OV]
                    | det[`BPRC_CB_OV];
        hard_raw[1] = 1'b0;
        // core over-voltage reaches the intermediate buck after 92us
        cbov_exp = det[`BPRC_CB_OV]
                 && (core_q.cbov_cnt >= last_f(FIX_MASK_CYC));
        hard_trig[0] = det[`BPRC_IB_OV] | det[`BPRC_ALR_OV]
                     | cbov_exp;
        hard_trig[1] = 1'b0;
        oc_last[0] = oc_mask_f(core_q.prot[`BPRC_IB_OC_LSB +: 2]);
        oc_last[1] = oc_mask_f(core_q.prot[`BPRC_CB_OC_LSB +: 2]);
        iv_last[0] = iv_f(core_q.prot[`BPRC_IB_IV_LSB +: 2]);
        iv_last[1] = iv_f(core_q.prot[`BPRC_CB_IV_LSB +: 2]);
        for (int c = 0; c < NCH; c++) begin
            oc_exp[c] = cond_oc[c] && (core_q.oc_cnt[c] >= oc_last[c]);
            lv_exp[c] = cond_lv[c]
                      && (core_q.lv_cnt[c] >= last_f(FIX_MASK_CYC));
            trig[c]   = oc_exp[c] | lv_exp[c] | hard_trig[c];
            cause[c]  = cond_oc[c] | cond_lv[c] | hard_raw[c];
        end
    end

    always_comb begin
        core_d = core_q;

        // setting register, untouched by the system reset output
        if (reg_wr && (reg_addr == `BPRC_ADDR_PROT)) begin
            core_d.prot = reg_wdata;
        end
        // unmapped addresses read zero
        core_d.rdata = (reg_addr == `BPRC_ADDR_PROT) ? core_q.prot : 8'h00;

        // a detection in the clearing cycle keeps its flag
        core_d.flags = (core_q.flags & ~flag_clear) | det;
        core_d.int_n = ~|core_d.flags;

        // mask timers, zeroed as soon as the condition drops
        if (!det[`BPRC_CB_OV]) begin
            core_d.cbov_cnt = '0;
        end else if (!cbov_exp) begin
            core_d.cbov_cnt = core_q.cbov_cnt + 1'b1;
        end

        for (int c = 0; c < NCH; c++) begin
            if (!cond_oc[c]) begin
                core_d.oc_cnt[c] = '0;
            end else if (!oc_exp[c]) begin
                core_d.oc_cnt[c] = core_q.oc_cnt[c] + 1'b1;
            end
            if (!cond_lv[c]) begin
                core_d.lv_cnt[c] = '0;
            end else if (!lv_exp[c]) begin
                core_d.lv_cnt[c] = core_q.lv_cnt[c] + 1'b1;
            end

            case (core_q.st[c])
                bprc_pkg::st_run: begin
                    if (trig[c]) begin
                        core_d.st[c] = bprc_pkg::st_arm;
                    end
                end
                // flag and interrupt land here, one cycle ahead of protect
                bprc_pkg::st_arm: begin
                    core_d.st[c]  = bprc_pkg::st_off;
                    core_d.tmr[c] = '0;
                end
                bprc_pkg::st_off: begin
                    if (core_q.tmr[c] >= iv_last[c]) begin
                        core_d.st[c]  = bprc_pkg::st_try;
                        core_d.tmr[c] = '0;
                    end else begin
                        core_d.tmr[c] = core_q.tmr[c] + 1'b1;
                    end
                end
                // restart attempt judged after one fixed mask window
                bprc_pkg::st_try: begin
                    if (core_q.tmr[c] >= last_f(FIX_MASK_CYC)) begin
                        core_d.tmr[c] = '0;
                        if (cause[c]) begin
                            core_d.st[c] = bprc_pkg::st_off;
                        end else begin
                            core_d.st[c] = bprc_pkg::st_run;
                        end
                    end else begin
                        core_d.tmr[c] = core_q.tmr[c] + 1'b1;
                    end
                end
                default: begin
                    core_d.st[c]  = bprc_pkg::st_off;
                    core_d.tmr[c] = '0;
                end
            endcase

            core_d.prot_mode[c] = (core_d.st[c] == bprc_pkg::st_off)
                                | (core_d.st[c] == bprc_pkg::st_try);
            // buck over-voltage wins over any state, both bucks stop together
            core_d.sw_en[c] = ((core_d.st[c] == bprc_pkg::st_run)
                            | (core_d.st[c] == bprc_pkg::st_try))
                            & ~halt;
        end

        // core rail reset, held while low and for the delay after recovery
        if (core_lv_reset_en && det[`BPRC_CB_LV]) begin
            core_d.rst_n   = 1'b0;
            core_d.rst_cnt = '0;
        end else if (!core_q.rst_n) begin
            if (core_q.rst_cnt >= last_f(RST_DLY_CYC)) begin
                core_d.rst_n   = 1'b1;
                core_d.rst_cnt = '0;
            end else begin
                core_d.rst_cnt = core_q.rst_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_q           <= '0;
            core_q.prot      <= `BPRC_PROT_RESET;
            core_q.int_n     <= 1'b1;
            core_q.st        <= {NCH{bprc_pkg::st_run}};
            core_q.sw_en     <= {NCH{1'b1}};
            core_q.rst_n     <= 1'b1;
        end else if (clk_en) begin
            core_q <= core_d;
        end
    end

    assign reg_rdata                   = core_q.rdata;
    assign fault_flags                 = core_q.flags;
    assign fault_interrupt_n           = core_q.int_n;
    assign intermediate_buck_switch_en = core_q.sw_en[0];
    assign core_buck_switch_en         = core_q.sw_en[1];
    assign intermediate_buck_protect   = core_q.prot_mode[0];
    assign core_buck_protect           = core_q.prot_mode[1];
    assign system_reset_n              = core_q.rst_n;

endmodule

// ---- sim/bprc_core_sva.sv ----
// port assertions for the protection block
module bprc_core_sva (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic       ib_ov_det,
    input wire logic       cb_ov_det,
    input wire logic       cb_lv_det,
    input wire logic       alr_ov_det,
    input wire logic       core_lv_reset_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] fault_flags,
    input wire logic       fault_interrupt_n,
    input wire logic       intermediate_buck_switch_en,
    input wire logic       core_buck_switch_en,
    input wire logic       intermediate_buck_protect,
    input wire logic       core_buck_protect,
    input wire logic       system_reset_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_int_flags: assert property (|fault_flags |-> !fault_interrupt_n)
        else $error("interrupt high with flag set");
    a_ib_int_first: assert property ($rose(intermediate_buck_protect)
        |-> !fault_interrupt_n && !$past(fault_interrupt_n))
        else $error("intermediate protect before interrupt");
    a_cb_int_first: assert property ($rose(core_buck_protect)
        |-> !fault_interrupt_n && !$past(fault_interrupt_n))
        else $error("core protect before interrupt");
    a_ib_ov_halt: assert property ((clk_en && ib_ov_det) [*7]
        |-> !intermediate_buck_switch_en && !core_buck_switch_en)
        else $error("switching on in intermediate over-voltage");
    a_cb_ov_halt: assert property ((clk_en && cb_ov_det) [*7]
        |-> !intermediate_buck_switch_en && !core_buck_switch_en)
        else $error("switching on in core over-voltage");
    a_alr_prot: assert property ((clk_en && alr_ov_det) [*8]
        |-> intermediate_buck_protect)
        else $error("regulator over-voltage left buck running");
    a_lv_sys_reset: assert property (
        (clk_en && core_lv_reset_en && cb_lv_det) [*7] |-> !system_reset_n)
        else $error("core low voltage without system reset");
    a_reg_write: assert property (
        (clk_en && reg_wr && reg_addr == 6'h1b)
        ##1 (clk_en && !reg_wr && reg_addr == 6'h1b)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("setting write not read back");
    a_unmapped_zero: assert property ((clk_en && reg_addr != 6'h1b)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind bprc_core bprc_core_sva u_sva (.*);

// ---- sim/bprc_host.sv ----
// host model driving the setting register port
module bprc_host (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // data inverted after the strobe so a stale byte is never reused
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 d = reg_rdata;
    endtask
endmodule

// ---- sim/bprc_core_tb.sv ----
// self-checking bench for the buck protection block
module bprc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       clk_en = 1'b1;
    logic       lv_en = 1'b0;
    logic [6:0] det = 7'h00;
    logic [6:0] flag_clear = 7'h00;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic       reg_wr, fault_interrupt_n, system_reset_n;
    logic [6:0] fault_flags;
    wire  [3:0] en_pr;
    int         err_total = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         n;

    // counts shortened so every retry fits a short run
    bprc_core #(.FIX_MASK_CYC(8), .OC_SHORT_CYC(10), .OC_MID_CYC(20),
        .OC_LONG_CYC(30), .IV_0_CYC(40), .IV_1_CYC(60), .IV_2_CYC(80),
        .IV_3_CYC(100), .RST_DLY_CYC(50)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .ib_ov_det(det[0]), .ib_oc_det(det[1]), .ib_lv_det(det[2]),
        .cb_ov_det(det[3]), .cb_oc_det(det[4]), .cb_lv_det(det[5]),
        .alr_ov_det(det[6]), .core_lv_reset_en(lv_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .flag_clear(flag_clear), .reg_rdata(reg_rdata),
        .fault_flags(fault_flags), .fault_interrupt_n(fault_interrupt_n),
        .intermediate_buck_switch_en(en_pr[0]),
        .core_buck_switch_en(en_pr[1]),
        .intermediate_buck_protect(en_pr[2]), .core_buck_protect(en_pr[3]),
        .system_reset_n(system_reset_n));
    bprc_host u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

    always #50 ref_clk = ~ref_clk;

    task close_out;
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            close_out();
        end
    end

    task chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task cyc(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    // whole detector word driven at once, one bit changed
    task put(input int k, input logic v);
        logic [6:0] nx;
        nx = det;
        nx[k] = v;
        @(posedge ref_clk);
        det <= nx;
        #1;
    endtask

    // 0..3 enables and protects, 4 system reset, 5 both bucks running
    function logic sig(input int c);
        return c < 4 ? en_pr[c] : (c == 4 ? system_reset_n
            : en_pr === 4'b0011);
    endfunction

    task wt(input int c, input logic v, input int lim);
        n = 0;
        while (sig(c) !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    task clear_flags;
        @(posedge ref_clk);
        flag_clear <= 7'h7f;
        @(posedge ref_clk);
        flag_clear <= 7'h00;
        cyc(2);
        chk(fault_flags === 7'h00 && fault_interrupt_n, "clear");
    endtask

    task s_regs;
        u_host.rd(6'h1b, d);
        chk(d === 8'h44, "default");
        u_host.rd(6'h05, d);
        chk(d === 8'h00, "unmapped read");
        u_host.wr(6'h05, 8'hff);
        u_host.rd(6'h1b, d);
        chk(d === 8'h44, "unmapped write");
        u_host.wr(6'h1b, 8'ha5);
        u_host.rd(6'h1b, d);
        chk(d === 8'ha5, "write");
    endtask

    // two pulses shorter than the mask but longer together
    task s_glitch;
        put(1, 1'b1);
        cyc(6);
        put(1, 1'b0);
        cyc(3);
        put(1, 1'b1);
        cyc(6);
        put(1, 1'b0);
        cyc(12);
        chk(sig(2) === 1'b0, "pulses tripped");
        chk(fault_flags[1] && !fault_interrupt_n, "flag");
        clear_flags();
    endtask

    task s_retry;
        int msk[4] = '{10, 10, 20, 30};
        int ivl[4] = '{40, 60, 80, 100};
        for (int k = 0; k < 4; k++) begin
            u_host.wr(6'h1b, {4'h0, k[1:0], k[1:0]});
            put(1, 1'b1);
            wt(2, 1'b1, 60);
            chk(n >= msk[k] && n <= msk[k] + 8, "mask");
            chk(!en_pr[0] && !fault_interrupt_n, "trip");
            wt(0, 1'b1, 200);
            chk(n >= ivl[k] - 2 && n <= ivl[k] + 2, "interval");
            put(1, 1'b0);
            wt(2, 1'b0, 40);
            chk(en_pr[0] === 1'b1 && n > 2, "no return");
            clear_flags();
        end
    endtask

    task s_core;
        u_host.wr(6'h1b, 8'h00);
        lv_en <= 1'b1;
        put(5, 1'b1);
        wt(4, 1'b0, 10);
        chk(system_reset_n === 1'b0, "no reset");
        wt(3, 1'b1, 40);
        chk(en_pr[3:1] === 3'b100 && !fault_interrupt_n, "trip");
        wt(1, 1'b1, 200);
        chk(n >= 38 && n <= 42, "interval");
        put(5, 1'b0);
        cyc(40);
        chk(system_reset_n === 1'b0, "early release");
        wt(4, 1'b1, 40);
        chk(system_reset_n && n >= 8 && n <= 20, "release");
        u_host.rd(6'h1b, d);
        chk(d === 8'h00, "setting lost");
        @(posedge ref_clk);
        lv_en <= 1'b0;
        wt(5, 1'b1, 400);
        clear_flags();
    endtask

    task s_ov;
        int idx[3] = '{0, 3, 6};
        for (int k = 0; k < 3; k++) begin
            put(idx[k], 1'b1);
            cyc(8);
            chk(fault_flags[idx[k]] === 1'b1, "ov flag");
            if (k < 2)
                chk(~|en_pr[1:0], "still on");
            else
                chk(en_pr[2] === 1'b1, "no protect");
            put(idx[k], 1'b0);
            wt(5, 1'b1, 400);
            chk(sig(5) === 1'b1, "no recovery");
            clear_flags();
        end
    endtask

    // frozen clock enable must ignore a detector pulse entirely
    task s_freeze;
        @(posedge ref_clk);
        clk_en <= 1'b0;
        put(0, 1'b1);
        cyc(12);
        chk(fault_interrupt_n === 1'b1 && sig(5) === 1'b1, "frozen");
        put(0, 1'b0);
        cyc(4);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        cyc(12);
        chk(fault_flags === 7'h00 && sig(5) === 1'b1, "pulse kept");
    endtask

    // fixed low-voltage mask and core current mask, then a failed retry
    task s_mask;
        int idx[2] = '{2, 4};
        int prt[2] = '{2, 3};
        int msk[2] = '{8, 10};
        for (int k = 0; k < 2; k++) begin
            put(idx[k], 1'b1);
            wt(prt[k], 1'b1, 40);
            chk(n >= msk[k] + 4 && n <= msk[k] + 6, "mask");
            wt(prt[k] - 2, 1'b1, 200);
            cyc(10);
            chk(!sig(prt[k] - 2) && sig(prt[k]), "retry");
            put(idx[k], 1'b0);
            wt(5, 1'b1, 400);
            chk(sig(5) === 1'b1, "no recovery");
            clear_flags();
        end
    endtask

    // mid-run reset returns the setting register to its default
    task s_rst;
        u_host.wr(6'h1b, 8'h3c);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(4);
        chk(fault_flags === 7'h00 && fault_interrupt_n, "reset");
        u_host.rd(6'h1b, d);
        chk(d === 8'h44, "reset value");
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(4);
        s_regs();
        s_glitch();
        s_retry();
        s_core();
        s_ov();
        s_freeze();
        s_mask();
        s_rst();
        close_out();
    end
endmodule
